// *** cpim_pkg.sv ***
// constants and types of the cascaded request mapping block
// Operation
// - sixteen maskable lines plus one unmaskable request
// - each line maps into 256-entry vector table
// - master lines 0-7, slave lines 8-15
// - master input 2 carries slave cascade only
// - slave input 1 (line 9) serves legacy line 2
// - master lines give vectors 08 to 0f
// - unmaskable request uses vector 02, firmware enabled
// - sources wired to documented line numbers
package cpim_pkg;
  localparam int CPIM_LINES = 16;
  localparam int CPIM_CTRL_INPUTS = 8;
  localparam int CPIM_CASCADE_INPUT = 2;
  localparam int CPIM_LEGACY_SLAVE_INPUT = 1;
  localparam logic [7:0] CPIM_MASTER_VEC_BASE = 8'h08;
  localparam logic [7:0] CPIM_NMI_VEC = 8'h02;
  localparam logic [9:0] CPIM_TABLE_LAST_BYTE = 10'h3ff;
  localparam logic [7:0] CPIM_SLAVE_VEC_BASE_RST = 8'h70;
  localparam logic [15:0] CPIM_MASK_RST = 16'hffff;
  localparam int CPIM_SRC_TIMER = 0;
  localparam int CPIM_SRC_KEYBOARD = 1;
  localparam int CPIM_SRC_SERIAL2 = 3;
  localparam int CPIM_SRC_SERIAL1 = 4;
  localparam int CPIM_SRC_FLOPPY = 6;
  localparam int CPIM_SRC_RTC = 8;
  localparam int CPIM_SRC_MOUSE = 12;
  localparam int CPIM_SRC_COPROC = 13;
  localparam int CPIM_SRC_HDD = 14;
  localparam int CPIM_SRC_FLASH = 15;

  typedef enum logic [2:0] {
    CPIM_IDLE = 3'b001,
    CPIM_PEND = 3'b010,
    CPIM_SERV = 3'b100
  } cpim_state_e;
endpackage : cpim_pkg

// *** cpim_prio8.sv ***
// one eight-input fixed priority request controller
`timescale 1ns/1ps
module cpim_prio8
  import cpim_pkg::*;
#(
  parameter int N = 8
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] mask,
  output logic any,
  output logic [2:0] idx
);
  if (N != 8) begin : g_bad_width
    $error("cpim_prio8 serves exactly eight inputs");
  end

  always_comb begin
    any = 1'b0;
    idx = 3'd0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && !mask[i]) begin
        any = 1'b1;
        idx = 3'(i);
      end
    end
  end
endmodule : cpim_prio8

// *** cpim_top.sv ***
// cascaded two-controller request mapping with unmaskable request
`timescale 1ns/1ps
module cpim_top
  import cpim_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic timer_req,
  input wire logic keyboard_req,
  input wire logic serial2_req,
  input wire logic serial1_req,
  input wire logic floppy_req,
  input wire logic rtc_req,
  input wire logic legacy_line2_req,
  input wire logic fw_line10_req,
  input wire logic fw_line11_req,
  input wire logic mouse_req,
  input wire logic coproc_req,
  input wire logic hdd_req,
  input wire logic flash_req,
  input wire logic parity_err_req,
  input wire logic bridge_vme_req,
  input wire logic nmi_enable,
  input wire logic [15:0] line_mask,
  input wire logic [7:0] slave_vec_base,
  input wire logic int_ack,
  output logic int_req,
  output logic nmi_req,
  output logic [7:0] int_vector,
  output logic [9:0] vector_addr,
  output logic vector_valid,
  output logic [15:0] pending_lines
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (CPIM_LINES != 2 * CPIM_CTRL_INPUTS) begin : g_bad_lines
    $error("line count must fill two controllers");
  end
  if (CPIM_CASCADE_INPUT >= CPIM_CTRL_INPUTS) begin : g_bad_cascade
    $error("cascade input lies outside the master");
  end
  if (CPIM_LEGACY_SLAVE_INPUT >= CPIM_CTRL_INPUTS) begin : g_bad_legacy
    $error("legacy input lies outside the slave");
  end

  // ----------------------------------------
  // synchronisers and state
  // ----------------------------------------
  typedef struct packed {
    logic [12:0] s1;
    logic [12:0] s2;
    logic [1:0] c1;
    logic [1:0] c2;
    logic [15:0] pend;
    cpim_state_e st;
    logic irq;
    logic nmi;
    logic [7:0] vec;
    logic [9:0] addr;
    logic vld;
  } cpim_s;

  cpim_s q_r;
  cpim_s q_nxt;

  logic [12:0] raw;
  logic [15:0] lines;
  logic m_any;
  logic s_any;
  logic [2:0] m_idx;
  logic [2:0] s_idx;
  logic [7:0] slave_grp;

  // ----------------------------------------
  // line wiring
  // ----------------------------------------
  always_comb begin
    lines = 16'h0000;
    lines[CPIM_SRC_TIMER] = q_r.s2[0];
    lines[CPIM_SRC_KEYBOARD] = q_r.s2[1];
    lines[CPIM_SRC_SERIAL2] = q_r.s2[2];
    lines[CPIM_SRC_SERIAL1] = q_r.s2[3];
    lines[CPIM_SRC_FLOPPY] = q_r.s2[4];
    lines[CPIM_SRC_RTC] = q_r.s2[5];
    lines[CPIM_CTRL_INPUTS + CPIM_LEGACY_SLAVE_INPUT] = q_r.s2[6];
    lines[10] = q_r.s2[7];
    lines[11] = q_r.s2[8];
    lines[CPIM_SRC_MOUSE] = q_r.s2[9];
    lines[CPIM_SRC_COPROC] = q_r.s2[10];
    lines[CPIM_SRC_HDD] = q_r.s2[11];
    lines[CPIM_SRC_FLASH] = q_r.s2[12];
  end

  // pin levels in synchroniser order, timer at bit 0
  assign raw = {
    flash_req,
    hdd_req,
    coproc_req,
    mouse_req,
    fw_line11_req,
    fw_line10_req,
    legacy_line2_req,
    rtc_req,
    floppy_req,
    serial1_req,
    serial2_req,
    keyboard_req,
    timer_req
  };

  // ----------------------------------------
  // cascaded controllers
  // ----------------------------------------
  cpim_prio8 #(.N(CPIM_CTRL_INPUTS)) u_slave (
    .req(lines[15:8]),
    .mask(line_mask[15:8]),
    .any(s_any),
    .idx(s_idx)
  );

  always_comb begin
    slave_grp = lines[7:0];
    slave_grp[CPIM_CASCADE_INPUT] = s_any;
  end

  cpim_prio8 #(.N(CPIM_CTRL_INPUTS)) u_master (
    .req(slave_grp),
    .mask(line_mask[7:0]),
    .any(m_any),
    .idx(m_idx)
  );

  // ----------------------------------------
  // vector selection
  // ----------------------------------------
  logic cascade_won;
  logic [7:0] master_vec;
  logic [7:0] slave_vec;
  logic [7:0] ack_vec;
  logic nmi_take;

  // slave vector only counts while the cascade input wins the master
  always_comb begin
    cascade_won = (m_idx == 3'(CPIM_CASCADE_INPUT));
    master_vec = CPIM_MASTER_VEC_BASE + {5'h00, m_idx};
    slave_vec = slave_vec_base + {5'h00, s_idx};
    ack_vec = cascade_won ? slave_vec : master_vec;
    nmi_take = q_r.nmi && int_ack && (q_r.st != CPIM_SERV);
  end

  // ----------------------------------------
  // acknowledge sequencing and vectors
  // ----------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = raw;
    q_nxt.s2 = q_r.s1;
    q_nxt.c1 = {bridge_vme_req, parity_err_req};
    q_nxt.c2 = q_r.c1;
    q_nxt.pend = lines & ~line_mask;
    q_nxt.nmi = nmi_enable && (q_r.c2 != 2'b00);
    q_nxt.vld = 1'b0;
    unique case (q_r.st)
      CPIM_IDLE: begin
        q_nxt.irq = m_any;
        if (m_any) begin
          q_nxt.st = CPIM_PEND;
        end
      end
      CPIM_PEND: begin
        q_nxt.irq = m_any;
        if (!m_any) begin
          q_nxt.st = CPIM_IDLE;
        end else if (int_ack) begin
          q_nxt.vec = ack_vec;
          q_nxt.vld = 1'b1;
          q_nxt.irq = 1'b0;
          q_nxt.st = CPIM_SERV;
        end
      end
      CPIM_SERV: begin
        q_nxt.addr = {q_r.vec, 2'b00} & CPIM_TABLE_LAST_BYTE;
        q_nxt.irq = 1'b0;
        if (!int_ack) begin
          q_nxt.st = CPIM_IDLE;
        end
      end
      default: begin
        q_nxt.st = CPIM_IDLE;
        q_nxt.irq = 1'b0;
      end
    endcase
    // a maskable acknowledge in the same cycle keeps its own vector
    if (nmi_take && !q_nxt.vld) begin
      q_nxt.vec = CPIM_NMI_VEC;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q_r <= '{
        s1: 13'h0000,
        s2: 13'h0000,
        c1: 2'h0,
        c2: 2'h0,
        pend: 16'h0000,
        st: CPIM_IDLE,
        irq: 1'b0,
        nmi: 1'b0,
        vec: 8'h00,
        addr: 10'h000,
        vld: 1'b0
      };
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // outputs straight from the state register
  // ----------------------------------------
  assign int_req = q_r.irq;
  assign nmi_req = q_r.nmi;
  assign int_vector = q_r.vec;
  assign vector_addr = q_r.addr;
  assign vector_valid = q_r.vld;
  assign pending_lines = q_r.pend;
endmodule : cpim_top

// *** cpim_cpu_model.sv ***
// processor side model that acknowledges requests
`timescale 1ns/1ps
module cpim_cpu_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic [3:0] lag,
  input wire logic int_req,
  input wire logic nmi_req,
  output logic int_ack
);
  logic [3:0] cnt_r;
  // ---------------------------------------------
  // acknowledge after lag cycles, hold for two
  // ---------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst || !enable) begin
      int_ack <= 1'b0;
      cnt_r <= 4'h0;
    end else if (int_ack) begin
      int_ack <= (cnt_r == 4'h0);
      cnt_r <= (cnt_r == 4'h0) ? 4'h1 : 4'h0;
    end else if (int_req || nmi_req) begin
      int_ack <= (cnt_r == lag);
      cnt_r <= (cnt_r == lag) ? 4'h0 : cnt_r + 4'h1;
    end
  end
endmodule : cpim_cpu_model

// *** cpim_chk.sv ***
// assertions on the request mapping outputs
`timescale 1ns/1ps
module cpim_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic nmi_enable,
  input wire logic int_ack,
  input wire logic int_req,
  input wire logic nmi_req,
  input wire logic [7:0] int_vector,
  input wire logic [9:0] vector_addr,
  input wire logic vector_valid,
  input wire logic [15:0] pending_lines
);
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  table_addr_a: assert property (vector_valid |=> vector_addr == {int_vector, 2'b00})
    else $error("bad addr");
  valid_pulse_a: assert property (vector_valid |=> !vector_valid)
    else $error("long valid");
  ack_vector_a: assert property (int_req && int_ack |=> vector_valid)
    else $error("no vector");
  req_drop_a: assert property (int_req && int_ack |=> !int_req)
    else $error("req held");
  master_vec_a: assert property (vector_valid && int_vector < 8'h10 |-> int_vector >= 8'h08)
    else $error("low vector");
  cascade_only_a: assert property (!pending_lines[2] && !(vector_valid && int_vector == 8'h0a))
    else $error("line two used");
  unused_lines_a: assert property (!pending_lines[5] && !pending_lines[7])
    else $error("unused line");
  nmi_gate_a: assert property (!nmi_enable [*4] |=> !nmi_req)
    else $error("nmi ungated");
  cover property (vector_valid && int_vector >= 8'h70);
  cover property (nmi_req && int_ack);
  cover property (int_req && int_ack);
endmodule : cpim_chk

bind cpim_top cpim_chk u_cpim_chk (.core_clk, .srst, .nmi_enable, .int_ack, .int_req, .nmi_req,
  .int_vector, .vector_addr, .vector_valid, .pending_lines);

// *** tb.sv ***
// testbench of the cascaded request mapping block
`timescale 1ns/1ps
module tb;
  import cpim_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] src = '0;
  logic [1:0] nmi_src = '0;
  logic nmi_enable = 1'b0;
  logic [15:0] line_mask = '0;
  logic en = 1'b0;
  logic [3:0] lag = 4'h0;
  logic int_ack, int_req, nmi_req, vector_valid;
  logic [7:0] int_vector;
  logic [9:0] vector_addr;
  logic [15:0] pending_lines;
  int err_total = 0;
  int checks_done = 0;
  int order[13] = '{0, 1, 8, 9, 10, 11, 12, 13, 14, 15, 3, 4, 6};
  cpim_top u_cpim_top (.core_clk, .srst, .timer_req(src[0]), .keyboard_req(src[1]),
    .serial2_req(src[3]), .serial1_req(src[4]), .floppy_req(src[6]), .rtc_req(src[8]),
    .legacy_line2_req(src[9]), .fw_line10_req(src[10]), .fw_line11_req(src[11]),
    .mouse_req(src[12]), .coproc_req(src[13]), .hdd_req(src[14]), .flash_req(src[15]),
    .parity_err_req(nmi_src[0]), .bridge_vme_req(nmi_src[1]), .nmi_enable, .line_mask,
    .slave_vec_base(8'h70), .int_ack, .int_req, .nmi_req, .int_vector, .vector_addr,
    .vector_valid, .pending_lines);
  cpim_cpu_model u_cpim_cpu_model (.core_clk, .srst, .enable(en), .lag, .int_req, .nmi_req,
    .int_ack);
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // serve line n and drop its source
  task automatic serve(input int n);
    logic [7:0] vec;
    int k;
    vec = (n < 8) ? 8'(8 + n) : 8'(8'h70 + n - 8);
    en <= 1'b1;
    k = 0;
    while (vector_valid !== 1'b1 && k < 40) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    check("valid", vector_valid, 1'b1);
    @(posedge core_clk);
    en <= 1'b0;
    src[n] <= 1'b0;
    #1;
    check("vector", int_vector, vec);
    check("addr", vector_addr, {vec, 2'b00});
    repeat (6) @(posedge core_clk);
  endtask : serve
  // ---------------------------------------------
  // sequence
  // ---------------------------------------------
  initial forever #10 core_clk = ~core_clk;
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    src <= 16'hff5b;
    repeat (6) @(posedge core_clk);
    #1 check("pending", pending_lines, 16'hff5b);
    @(posedge core_clk);
    foreach (order[i]) begin
      lag <= 4'(i % 3);
      serve(order[i]);
    end
    line_mask <= 16'h000c;
    src <= 16'h1008;
    repeat (6) @(posedge core_clk);
    #1 check("masked", int_req, 1'b0);
    @(posedge core_clk);
    line_mask <= '0;
    serve(12);
    serve(3);
    nmi_src <= 2'b11;
    repeat (6) @(posedge core_clk);
    #1 check("nmi off", nmi_req, 1'b0);
    @(posedge core_clk);
    nmi_enable <= 1'b1;
    line_mask <= 16'hffff;
    repeat (6) @(posedge core_clk);
    #1 check("nmi on", nmi_req, 1'b1);
    @(posedge core_clk);
    en <= 1'b1;
    repeat (5) @(posedge core_clk);
    #1 check("nmi vec", int_vector, 8'h02);
    conclude();
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    conclude();
  end
endmodule : tb
